// >>> rtl/scd_pkg.sv
// system clock divider and rc trim: shared constants, types and helpers
// assumes a 32-bit axi4-lite register port and one undivided source clock
package scd_pkg;

    // register map, byte addresses on an 8-bit address bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] TRIM_OFFSET = 8'h00;
    localparam logic [7:0] CTRL_OFFSET = 8'h04;

    // divider control layout
    localparam int UNLOCK_BIT = 7;
    localparam logic [7:0] UNLOCK_PATTERN = 8'h80;
    localparam logic [3:0] SEL_RESET_PLAIN = 4'h0;
    localparam logic [3:0] SEL_RESET_DIV8 = 4'h3;
    localparam logic [3:0] SEL_MAX_VALID = 4'h8;

    // trim layout
    localparam int TRIM_RANGE_BIT = 7;

    // unlock window length in source clock cycles
    localparam int UNLOCK_WINDOW_CYCLES = 4;
    localparam logic [1:0] UNLOCK_TIMER_LOAD = 2'(UNLOCK_WINDOW_CYCLES - 1);

    // cycles after reset release before straps are taken
    localparam logic [1:0] BOOT_SETTLE = 2'h3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed
    {
        logic unlock;
        logic [2:0] rsvd;
        logic [3:0] sel;
    } scd_ctrl_t;

    typedef enum logic [1:0] {SCD_REG_TRIM, SCD_REG_CTRL, SCD_REG_NONE} scd_reg_t;

    function automatic scd_reg_t scd_decode(input logic [ADDR_W-1:0] addr);
        scd_reg_t r;
        r = SCD_REG_NONE;
        if (addr[ADDR_W-1:2] == TRIM_OFFSET[ADDR_W-1:2])
            r = SCD_REG_TRIM;
        else if (addr[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2])
            r = SCD_REG_CTRL;
        return r;
    endfunction

    // last count value of one divided period: factor minus one
    function automatic logic [7:0] scd_last(input logic [3:0] sel);
        logic [8:0] f;
        f = 9'h001 << sel;
        return 8'(f - 9'h001);
    endfunction

endpackage

// >>> rtl/scd_top.sv
// system clock divider with timed unlock, and rc oscillator trim register
// assumes i_clock is the undivided source clock; straps are static pins
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns

// Function
// - divided tick paces cpu, flash, io, adc
// - divider sits between any source and system
// - switch only at period end, no glitch
// - counter on source clock, never readable
// - new rate active within old plus new period
// - factory trim byte loaded after reset release
// - trim write retunes oscillator at once
// - trim top bit selects overlapping range
// - low seven trim bits tune monotonically
// - unlock set only by exact 0x80 write
// - unlock clears after four cycles or select
// - select changes only inside unlock window
// - reset select from divide-by-eight fuse
// - any select value writable regardless fuse
// - codes 0 to 8 divide 1 to 256
module scd_top
(
    input wire logic I_CLOCK,
    input wire logic I_RST,
    input wire logic I_DIV8_FUSE_PROGRAMMED,
    input wire logic [7:0] I_FACTORY_TRIM,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [scd_pkg::ADDR_W-1:0] I_AWADDR,
    input wire logic [2:0] I_AWPROT,
    input wire logic I_WVALID,
    output logic O_WREADY,
    input wire logic [scd_pkg::DATA_W-1:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    output logic O_BVALID,
    input wire logic I_BREADY,
    output logic [1:0] O_BRESP,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    input wire logic [scd_pkg::ADDR_W-1:0] I_ARADDR,
    input wire logic [2:0] I_ARPROT,
    output logic O_RVALID,
    input wire logic I_RREADY,
    output logic [scd_pkg::DATA_W-1:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_SYS_TICK,
    output logic [3:0] O_DIV_SELECT,
    output logic [7:0] O_TRIM_VALUE,
    output logic O_TRIM_RANGE,
    output logic [6:0] O_TRIM_FINE
);
    import scd_pkg::*;

    // strap capture after release
    logic fuse_s1, fuse_s2, fuse_s3;
    logic [7:0] ftrim_s1, ftrim_s2, ftrim_s3;
    logic [1:0] boot_cnt;
    logic loaded;

    // registers
    logic [7:0] trim;
    scd_ctrl_t ctrl;
    logic [1:0] unlock_tmr;

    // divider
    logic [7:0] div_cnt;
    logic [3:0] active_sel;
    logic [3:0] pend_sel;
    logic pend;
    logic tick_q;

    // axi state
    logic aw_held, w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;

    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            fuse_s1 <= 1'b0;
            fuse_s2 <= 1'b0;
            fuse_s3 <= 1'b0;
            ftrim_s1 <= 8'h00;
            ftrim_s2 <= 8'h00;
            ftrim_s3 <= 8'h00;
        end
        else
        begin
            fuse_s1 <= I_DIV8_FUSE_PROGRAMMED;
            fuse_s2 <= fuse_s1;
            fuse_s3 <= fuse_s2;
            ftrim_s1 <= I_FACTORY_TRIM;
            ftrim_s2 <= ftrim_s1;
            ftrim_s3 <= ftrim_s2;
        end
    end

    // straps are taken once the settle count is done and the last two stages agree; bus stays closed until then
    wire straps_stable = (fuse_s2 == fuse_s3) && (ftrim_s2 == ftrim_s3);
    wire boot_load = !loaded && (boot_cnt == BOOT_SETTLE) && straps_stable;
    wire [3:0] boot_sel = fuse_s3 ? SEL_RESET_DIV8 : SEL_RESET_PLAIN;

    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            boot_cnt <= 2'h0;
            loaded <= 1'b0;
        end
        else
        begin
            if (boot_cnt != BOOT_SETTLE)
                boot_cnt <= boot_cnt + 2'h1;
            if (boot_load)
                loaded <= 1'b1;
        end
    end

    // axi4-lite write path
    wire aw_fire = I_AWVALID && O_AWREADY;
    wire w_fire = I_WVALID && O_WREADY;
    wire wr_fire = aw_held && w_held && !bvalid;
    wire scd_reg_t wr_reg = scd_decode(aw_addr);
    wire wr_lane0 = wr_fire && w_strb[0];
    wire [7:0] wr_byte = w_data[7:0];
    wire wr_trim = wr_lane0 && (wr_reg == SCD_REG_TRIM);
    wire wr_ctrl = wr_lane0 && (wr_reg == SCD_REG_CTRL);

    assign O_AWREADY = loaded && !aw_held;
    assign O_WREADY = loaded && !w_held;

    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end
        else
        begin
            if (aw_fire)
            begin
                aw_held <= 1'b1;
                aw_addr <= I_AWADDR;
            end
            else if (wr_fire)
                aw_held <= 1'b0;
            if (w_fire)
            begin
                w_held <= 1'b1;
                w_data <= I_WDATA;
                w_strb <= I_WSTRB;
            end
            else if (wr_fire)
                w_held <= 1'b0;
            if (wr_fire)
            begin
                bvalid <= 1'b1;
                bresp <= (wr_reg == SCD_REG_NONE) ? RESP_SLVERR : RESP_OKAY;
            end
            else if (I_BREADY)
                bvalid <= 1'b0;
        end
    end

    // unlock: exact pattern only, fixed window, rewrite neither extends nor clears
    wire unlock_set = wr_ctrl && (wr_byte == UNLOCK_PATTERN) && !ctrl.unlock;
    wire sel_wr = wr_ctrl && ctrl.unlock && !wr_byte[UNLOCK_BIT];
    wire sel_ok = sel_wr && (wr_byte[3:0] <= SEL_MAX_VALID);
    wire unlock_expire = ctrl.unlock && (unlock_tmr == 2'h0);

    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            trim <= 8'h00;
            ctrl <= '0;
            unlock_tmr <= 2'h0;
        end
        else
        begin
            if (boot_load)
                trim <= ftrim_s3;
            else if (wr_trim)
                trim <= wr_byte;
            if (boot_load)
                ctrl.sel <= boot_sel;
            else if (sel_wr)
                ctrl.sel <= wr_byte[3:0];
            if (sel_wr || unlock_expire)
                ctrl.unlock <= 1'b0;
            else if (unlock_set)
                ctrl.unlock <= 1'b1;
            if (unlock_set)
                unlock_tmr <= UNLOCK_TIMER_LOAD;
            else if (ctrl.unlock && unlock_tmr != 2'h0)
                unlock_tmr <= unlock_tmr - 2'h1;
        end
    end

    // divider: a pending select is taken only at the end of the running period
    wire tick = loaded && (div_cnt == scd_last(active_sel));
    wire next_pend = sel_ok || (pend && !tick);

    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            div_cnt <= 8'h00;
            active_sel <= SEL_RESET_PLAIN;
            pend_sel <= SEL_RESET_PLAIN;
            pend <= 1'b0;
            tick_q <= 1'b0;
        end
        else
        begin
            div_cnt <= (!loaded || tick) ? 8'h00 : div_cnt + 8'h01;
            if (boot_load)
                active_sel <= boot_sel;
            else if (tick && pend)
                active_sel <= pend_sel;
            if (sel_ok)
                pend_sel <= wr_byte[3:0];
            pend <= next_pend;
            tick_q <= tick;
        end
    end

    // axi4-lite read path; the divider count is deliberately not mapped
    wire ar_fire = I_ARVALID && O_ARREADY;
    wire scd_reg_t rd_reg = scd_decode(I_ARADDR);
    wire [7:0] ctrl_byte = {ctrl.unlock, 3'b000, ctrl.sel};
    wire [31:0] rd_word = (rd_reg == SCD_REG_TRIM) ? {24'h000000, trim}
                        : (rd_reg == SCD_REG_CTRL) ? {24'h000000, ctrl_byte} : 32'h00000000;

    assign O_ARREADY = loaded && !rvalid;

    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= RESP_OKAY;
        end
        else
        begin
            if (ar_fire)
            begin
                rvalid <= 1'b1;
                rdata <= rd_word;
                rresp <= (rd_reg == SCD_REG_NONE) ? RESP_SLVERR : RESP_OKAY;
            end
            else if (I_RREADY)
                rvalid <= 1'b0;
        end
    end

    assign O_BVALID = bvalid;
    assign O_BRESP = bresp;
    assign O_RVALID = rvalid;
    assign O_RDATA = rdata;
    assign O_RRESP = rresp;
    assign O_SYS_TICK = tick_q;
    assign O_DIV_SELECT = active_sel;
    // analog trim: range bit picks band, fine bits rise monotonic within it
    assign O_TRIM_VALUE = trim;
    assign O_TRIM_RANGE = trim[TRIM_RANGE_BIT];
    assign O_TRIM_FINE = trim[6:0];

    // checking helpers: cycles since last tick, whether a tick has been seen
    logic [8:0] gap;
    logic seen_tick;
    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            gap <= 9'h000;
            seen_tick <= 1'b0;
        end
        else
        begin
            gap <= tick ? 9'h000 : gap + 9'h001;
            if (tick)
                seen_tick <= 1'b1;
        end
    end

    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (I_RST);

    AST_UNLOCK_TIMEOUT: assert property ($rose(ctrl.unlock) |-> ##4 !ctrl.unlock)
        else $error("unlock bit outlived its four cycle window");
    AST_UNLOCK_PATTERN: assert property ($rose(ctrl.unlock) |-> $past(wr_ctrl) && $past(wr_byte) == 8'h80)
        else $error("unlock bit set without exact pattern write");
    AST_SEL_NEEDS_UNLOCK: assert property (loaded && $past(loaded) && $changed(ctrl.sel)
        |-> $past(ctrl.unlock) && $past(wr_ctrl) && !$past(wr_byte[7]))
        else $error("select field changed outside unlock window");
    AST_SEL_CLEARS_UNLOCK: assert property (ctrl.unlock && wr_ctrl && !wr_byte[7] |=> !ctrl.unlock)
        else $error("select write did not clear unlock");
    AST_SWITCH_AT_BOUNDARY: assert property (loaded && $past(loaded) && $changed(active_sel) |-> $past(tick))
        else $error("division changed in mid period");
    AST_PERIOD_EXACT: assert property (tick && seen_tick |-> gap == {1'b0, scd_last(active_sel)})
        else $error("tick spacing does not match active factor");
    AST_SWITCH_LATENCY: assert property ($rose(pend) |-> ##[1:257] !pend)
        else $error("new division not applied within one old period");
    AST_NO_RESERVED_ACTIVE: assert property (active_sel <= 4'h8)
        else $error("reserved select code became active");
    AST_FUSE_RESET: assert property ($rose(loaded) |-> ctrl.sel == (fuse_s3 ? 4'h3 : 4'h0)
        && trim == $past(ftrim_s3))
        else $error("reset select or trim not taken from straps");
    AST_TRIM_WRITE: assert property (loaded && wr_trim |=> O_TRIM_VALUE == $past(wr_byte))
        else $error("trim write did not reach oscillator");
    AST_UNLOCK_WRITE_GUARD: assert property (ctrl.unlock && wr_ctrl && wr_byte == 8'h80
        |=> $stable(ctrl.sel) && ctrl.unlock == ($past(unlock_tmr) != 2'h0) && unlock_tmr != UNLOCK_TIMER_LOAD)
        else $error("rewrite of unlock changed state");

endmodule

// >>> sim/scd_top_tb.sv
// self-checking bench for the clock divider and rc trim block
// assumes scd_pkg and scd_top are compiled first; drives the axi4-lite port directly
`timescale 1ns/1ns
module scd_top_tb;
    import scd_pkg::*;
    logic clock;
    logic rst;
    logic fuse;
    logic [7:0] factory;
    logic awvalid;
    logic wvalid;
    logic arvalid;
    logic [ADDR_W-1:0] awaddr;
    logic [ADDR_W-1:0] araddr;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    wire awready, wready, bvalid, arready, rvalid, tick, trim_range;
    wire [1:0] bresp;
    wire [1:0] rresp;
    wire [DATA_W-1:0] rdata;
    wire [3:0] div_sel;
    wire [7:0] trim_value;
    wire [6:0] trim_fine;
    int num_errors;
    int checked;
    int n;
    logic [31:0] rd;
    logic [1:0] rsp;

    scd_top i_dut
    (
        .I_CLOCK(clock), .I_RST(rst), .I_DIV8_FUSE_PROGRAMMED(fuse), .I_FACTORY_TRIM(factory),
        .I_AWVALID(awvalid), .O_AWREADY(awready), .I_AWADDR(awaddr), .I_AWPROT(3'h0),
        .I_WVALID(wvalid), .O_WREADY(wready), .I_WDATA(wdata), .I_WSTRB(wstrb),
        .O_BVALID(bvalid), .I_BREADY(1'b1), .O_BRESP(bresp),
        .I_ARVALID(arvalid), .O_ARREADY(arready), .I_ARADDR(araddr), .I_ARPROT(3'h0),
        .O_RVALID(rvalid), .I_RREADY(1'b1), .O_RDATA(rdata), .O_RRESP(rresp),
        .O_SYS_TICK(tick), .O_DIV_SELECT(div_sel), .O_TRIM_VALUE(trim_value),
        .O_TRIM_RANGE(trim_range), .O_TRIM_FINE(trim_fine)
    );

    always #5 clock = ~clock;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // bready and rready stay high, so the answer is taken at the edge it is seen
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        logic aw_done;
        logic w_done;
        aw_done = 0;
        w_done = 0;
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        while (!(aw_done && w_done))
        begin
            @(posedge clock);
            if (awvalid && awready === 1'b1)
            begin
                aw_done = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready === 1'b1)
            begin
                w_done = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clock); while (bvalid !== 1'b1);
        r = bresp;
    endtask

    task rdt(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        arvalid <= 1'b1;
        araddr <= a;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clock); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask

    // cycles between two consecutive divided ticks
    task period(output int p);
        p = 0;
        do @(posedge clock); while (tick !== 1'b1);
        do
        begin
            @(posedge clock);
            p++;
        end
        while (tick !== 1'b1);
    endtask

    // unlock then select, back to back so the second write lands inside the window
    task set_sel(input logic [7:0] code);
        wr(CTRL_OFFSET, 32'h80, 4'hF, rsp);
        wr(CTRL_OFFSET, 32'(code), 4'hF, rsp);
    endtask

    task do_reset(input logic f, input logic [7:0] t);
        rst <= 1'b1;
        fuse <= f;
        factory <= t;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        repeat (8) @(posedge clock);
    endtask

    task results;
        if (num_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        #900000;
        num_errors++;
        results();
    end

    initial
    begin
        clock = 0;
        rst = 1;
        fuse = 0;
        factory = 8'h00;
        awvalid = 0;
        wvalid = 0;
        arvalid = 0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'hF;
        num_errors = 0;
        checked = 0;
        do_reset(1'b1, 8'hA5);
        rdt(TRIM_OFFSET, rd, rsp);
        chk(rd, 32'hA5);
        chk(32'(trim_value), 32'hA5);
        rdt(CTRL_OFFSET, rd, rsp);
        chk(rd, 32'h03);
        period(n);
        chk(32'(n), 32'd8);
        wr(TRIM_OFFSET, 32'h7F, 4'hF, rsp);
        chk(32'(trim_range), 32'h0);
        chk(32'(trim_fine), 32'h7F);
        rdt(TRIM_OFFSET, rd, rsp);
        chk(rd, 32'h7F);
        wr(TRIM_OFFSET, 32'h80, 4'hF, rsp);
        chk(32'(trim_range), 32'h1);
        chk(32'(trim_fine), 32'h00);
        // no lane enabled: register must keep its value
        wr(TRIM_OFFSET, 32'h11, 4'h0, rsp);
        chk(32'(rsp), 32'(RESP_OKAY));
        chk(32'(trim_value), 32'h80);
        wr(8'h08, 32'h80, 4'hF, rsp);
        chk(32'(rsp), 32'(RESP_SLVERR));
        rdt(8'h08, rd, rsp);
        chk(rd, 32'h0);
        chk(32'(rsp), 32'(RESP_SLVERR));
        wr(CTRL_OFFSET, 32'h05, 4'hF, rsp);
        rdt(CTRL_OFFSET, rd, rsp);
        chk(rd, 32'h03);
        wr(CTRL_OFFSET, 32'h81, 4'hF, rsp);
        wr(CTRL_OFFSET, 32'h05, 4'hF, rsp);
        rdt(CTRL_OFFSET, rd, rsp);
        chk(rd, 32'h03);
        // a rewrite of the unlock must not stretch the window
        wr(CTRL_OFFSET, 32'h80, 4'hF, rsp);
        wr(CTRL_OFFSET, 32'h80, 4'hF, rsp);
        wr(CTRL_OFFSET, 32'h05, 4'hF, rsp);
        rdt(CTRL_OFFSET, rd, rsp);
        chk(rd, 32'h03);
        for (int c = 0; c <= 8; c++)
        begin
            set_sel(8'(c));
            rdt(CTRL_OFFSET, rd, rsp);
            chk(rd, 32'(c));
            repeat ((c == 0 ? 8 : (1 << (c - 1))) + 4) @(posedge clock);
            chk(32'(div_sel), 32'(c));
            period(n);
            chk(32'(n), 32'(1 << c));
        end
        set_sel(8'h09);
        rdt(CTRL_OFFSET, rd, rsp);
        chk(rd, 32'h09);
        period(n);
        chk(32'(n), 32'd256);
        set_sel(8'h72);
        rdt(CTRL_OFFSET, rd, rsp);
        chk(rd, 32'h02);
        period(n);
        period(n);
        chk(32'(n), 32'd4);
        // second reset in mid-run with the fuse left unprogrammed
        do_reset(1'b0, 8'h3C);
        rdt(CTRL_OFFSET, rd, rsp);
        chk(rd, 32'h00);
        rdt(TRIM_OFFSET, rd, rsp);
        chk(rd, 32'h3C);
        period(n);
        chk(32'(n), 32'd1);
        set_sel(8'h08);
        rdt(CTRL_OFFSET, rd, rsp);
        chk(rd, 32'h08);
        results();
    end
endmodule
